// ==== shared/bor_pkg.sv ====
// Package of constants and types for the brown-out reset mode control block.
// Functional notes
// [RULE1] Mode 11 keeps brown-out reset enabled in every state.
// [RULE2] In modes 11 and 10 start-up waits for detector ready and supply ok.
// [RULE3] In mode 11 protection stays on in Sleep and wake-up never waits.
// [RULE4] Mode 10 enables brown-out reset while running, not in Sleep.
// [RULE5] In mode 10 wake-up waits for detector ready and supply ok.
// [RULE6] Mode 01 follows the software brown-out enable bit.
// [RULE7] Mode 01 skips the wait only with enable clear after a warm reset.
// [RULE8] Protection starts once the detector is ready; a flag mirrors it.
// [RULE9] In mode 01 Sleep entry or exit leaves protection unchanged.
// [RULE10] Mode 00 keeps brown-out reset off whatever the software enable.
// [RULE11] Nine reset sources, power-on and brown-out among them, are taken.
// [RULE12] An optional power-up timer stretches reset after a cold event.
// [RULE13] Low supply with protection active asserts and records a reset.
package bor_pkg;
  // ==========================================================================
  // Mode encodings.
  localparam logic [1:0] BOR_MODE_OFF    = 2'h0;
  localparam logic [1:0] BOR_MODE_SW     = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLP  = 2'h2;
  localparam logic [1:0] BOR_MODE_ON     = 2'h3;
  // ==========================================================================
  // Reset source indices.
  localparam int BOR_NSRC        = 9;
  localparam int BOR_SRC_POR     = 0;
  localparam int BOR_SRC_BOR     = 1;
  localparam int BOR_SRC_LOW_POWER_BROWNOUT_RESET   = 2;
  localparam int BOR_SRC_MASTER_CLEAR_PIN    = 3;
  localparam int BOR_SRC_WDOG    = 4;
  localparam int BOR_SRC_RSTI    = 5;
  localparam int BOR_SRC_STKO    = 6;
  localparam int BOR_SRC_STKU    = 7;
  localparam int BOR_SRC_PGMX    = 8;
  localparam logic [BOR_NSRC-1:0] BOR_SRC_NONE = 9'h000;
  // ==========================================================================
  // Timing: power-up timer length.
  localparam int BOR_CLK_MHZ     = 125;
  localparam int BOR_PWRT_US     = 64;
  localparam int BOR_PWRT_CYC    = BOR_PWRT_US * BOR_CLK_MHZ;
  localparam int BOR_CNT_W       = 14;
  localparam logic [BOR_CNT_W-1:0] BOR_CNT_ZERO = 14'h0000;
  localparam logic [BOR_CNT_W-1:0] BOR_CNT_ONE  = 14'h0001;
  // ==========================================================================
  // Detector inputs travel together.
  typedef struct packed {
    logic ready;
    logic low;
  } bor_det_s;
  // Sequencer states.
  typedef enum logic [3:0] {
    BOR_ST_HOLD  = 4'h1,
    BOR_ST_PWRT  = 4'h2,
    BOR_ST_RUN   = 4'h4,
    BOR_ST_SLEEP = 4'h8
  } bor_state_e;
endpackage

// ==== design/bor_src_latch.sv ====
// Sticky latch of reset source flags.
`timescale 1ns/10ps
module bor_src_latch
  import bor_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Source events and clears.
  input  wire logic [BOR_NSRC-1:0] src_evt,
  input  wire logic [BOR_NSRC-1:0] src_clr,
  // Recorded flags.
  output logic      [BOR_NSRC-1:0] src_flags
);
  // ==========================================================================
  // One flag per source; a set arriving with a clear wins.
  genvar i;
  generate
    for (i = 0; i < BOR_NSRC; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          src_flags[i] <= 1'b0;
        end else if (src_evt[i]) begin
          src_flags[i] <= 1'b1; // [RULE11]
        end else if (src_clr[i]) begin
          src_flags[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ==== design/bor_pwrt.sv ====
// Power-up timer counting down a fixed interval.
`timescale 1ns/10ps
module bor_pwrt
  import bor_pkg::*;
#(
  parameter logic [BOR_CNT_W-1:0] PWRT_CYCLES = BOR_CNT_W'(BOR_PWRT_CYC)
)
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Control.
  input  wire logic start,
  // Status.
  output logic      busy
);
  // ==========================================================================
  logic [BOR_CNT_W-1:0] cnt_reg;
  logic [BOR_CNT_W-1:0] cnt_next;

  // Reload on start, otherwise count down to zero.
  assign cnt_next = start ? PWRT_CYCLES :
                    (cnt_reg != BOR_CNT_ZERO) ? cnt_reg - BOR_CNT_ONE :
                    BOR_CNT_ZERO;
  assign busy     = (cnt_reg != BOR_CNT_ZERO);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= BOR_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ==== design/bor_mode_ctrl.sv ====
// Brown-out reset mode control and start-up sequencer.
`timescale 1ns/10ps
module bor_mode_ctrl
  import bor_pkg::*;
#(
  parameter logic [BOR_CNT_W-1:0] PWRT_CYCLES = BOR_CNT_W'(BOR_PWRT_CYC)
)
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Configuration.
  input  wire logic [1:0]          brownout_mode_cfg,
  input  wire logic                pwrt_enable,
  input  wire logic                sw_brownout_enable,
  // Analog detector.
  input  wire bor_det_s            det,
  // Other reset sources, one-cycle pulses.
  input  wire logic                power_on_reset,
  input  wire logic                low_power_brownout_reset,
  input  wire logic                master_clear_pin,
  input  wire logic                watchdog_timeout,
  input  wire logic                reset_instr,
  input  wire logic                stack_overflow,
  input  wire logic                stack_underflow,
  input  wire logic                prog_mode_exit,
  // Sleep control.
  input  wire logic                sleep_req,
  input  wire logic                wake_req,
  // Reset flag clears from software.
  input  wire logic [BOR_NSRC-1:0] src_clr,
  // Status and outputs.
  output logic                     brownout_ready_flag,
  output logic                     brownout_active,
  output logic                     detector_enable,
  output logic                     core_reset,
  output logic                     sleeping,
  output logic [BOR_NSRC-1:0]      reset_flags
);
  // ==========================================================================
  // Mode decoding.
  wire mode_on    = (brownout_mode_cfg == BOR_MODE_ON);
  wire mode_noslp = (brownout_mode_cfg == BOR_MODE_NOSLP);
  wire mode_sw    = (brownout_mode_cfg == BOR_MODE_SW);

  bor_state_e state_reg;
  bor_state_e state_next;
  logic       cold_reg;
  logic       cold_next;
  logic       ready_reg;
  logic       core_reset_reg;

  wire in_sleep = (state_reg == BOR_ST_SLEEP);

  // ==========================================================================
  // Detector enable per mode. The software mode enable does not depend on Sleep.
  wire en_on    = mode_on;                              // [RULE1] [RULE3]
  // In mode 10 a wake request powers the detector so that wake-up can wait
  // for it; the rest of Sleep keeps it off to save power.
  wire en_noslp = mode_noslp && (!in_sleep || wake_req); // [RULE4] [RULE5]
  wire en_sw    = mode_sw && sw_brownout_enable;        // [RULE6] [RULE9]
  assign detector_enable = en_on | en_noslp | en_sw;    // [RULE10]

  // Protection only starts once the detector reports ready, and in mode 10
  // it stays off in Sleep even while the detector warms up for a wake.
  wire prot_en = en_on | en_sw | (mode_noslp && !in_sleep); // [RULE4]
  assign brownout_active = prot_en && det.ready;        // [RULE8]
  wire bor_trip = brownout_active && det.low;           // [RULE13]

  // ==========================================================================
  // Start-up wait: in software mode skipped only when the enable is clear
  // and the previous reset was not power-on or brown-out.
  wire sw_skip  = mode_sw && !sw_brownout_enable && !cold_reg; // [RULE7]
  wire need_wait_start = mode_on || mode_noslp ||
                         (mode_sw && !sw_skip);         // [RULE2]
  wire supply_ok = det.ready && !det.low;
  wire start_ok  = !need_wait_start || supply_ok;       // [RULE2] [RULE7]
  // Wake waits in mode 10, and in mode 01 unless the start-up wait is skipped; mode 11 wakes at once.
  wire wake_wait = mode_noslp ||
                   (mode_sw && !sw_skip);               // [RULE5] [RULE3]
  wire wake_ok   = !wake_wait || supply_ok;             // [RULE5]

  // ==========================================================================
  // Reset source gathering.
  wire any_warm = low_power_brownout_reset | master_clear_pin |
                  watchdog_timeout | reset_instr | stack_overflow |
                  stack_underflow | prog_mode_exit;
  wire cold_evt = power_on_reset | bor_trip;
  wire any_rst  = cold_evt | any_warm;

  logic [BOR_NSRC-1:0] src_evt;
  assign src_evt = {prog_mode_exit, stack_underflow, stack_overflow,
                    reset_instr, watchdog_timeout, master_clear_pin,
                    low_power_brownout_reset, bor_trip,
                    power_on_reset};                    // [RULE11] [RULE13]

  // The power-up timer runs only after cold events when enabled.
  wire pwrt_start = cold_evt && pwrt_enable;            // [RULE12]
  logic pwrt_busy;

  bor_pwrt #(
    .PWRT_CYCLES (PWRT_CYCLES)
  ) u_pwrt (
    .clk   (clk),
    .rst_n (rst_n),
    .start (pwrt_start),
    .busy  (pwrt_busy)
  );

  bor_src_latch u_src (
    .clk       (clk),
    .rst_n     (rst_n),
    .src_evt   (src_evt),
    .src_clr   (src_clr),
    .src_flags (reset_flags)
  );

  // ==========================================================================
  // Cold-start memory: set by power-on or brown-out, cleared by warm resets.
  assign cold_next = cold_evt ? 1'b1 : (any_warm ? 1'b0 : cold_reg);

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BOR_ST_HOLD: begin
        if (!any_rst && start_ok) begin
          state_next = pwrt_busy ? BOR_ST_PWRT : BOR_ST_RUN;
        end
      end
      BOR_ST_PWRT: begin
        if (any_rst) begin
          state_next = BOR_ST_HOLD;
        end else if (!pwrt_busy) begin
          state_next = BOR_ST_RUN;          // [RULE12]
        end
      end
      BOR_ST_RUN: begin
        if (any_rst) begin
          state_next = BOR_ST_HOLD;
        end else if (sleep_req) begin
          state_next = BOR_ST_SLEEP;
        end
      end
      BOR_ST_SLEEP: begin
        if (any_rst) begin
          state_next = BOR_ST_HOLD;
        end else if (wake_req && wake_ok) begin
          state_next = BOR_ST_RUN;          // [RULE3] [RULE5]
        end
      end
      default: begin
        state_next = BOR_ST_HOLD;
      end
    endcase
  end

  // ==========================================================================
  // State, cold flag and registered status. Reset starts as a cold start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BOR_ST_HOLD;
      cold_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      cold_reg  <= cold_next;
    end
  end

  // Outputs from flip-flops; readiness mirrors the detector.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg      <= 1'b0;
      core_reset_reg <= 1'b1;
    end else begin
      ready_reg      <= det.ready;          // [RULE8]
      core_reset_reg <= (state_next == BOR_ST_HOLD) ||
                        (state_next == BOR_ST_PWRT); // [RULE13]
    end
  end

  assign brownout_ready_flag = ready_reg;
  assign core_reset          = core_reset_reg;
  assign sleeping            = in_sleep;
endmodule

// ==== bench/bor_det_model.sv ====
// Behavioural model of the analog brown-out detector.
`timescale 1ns/10ps
module bor_det_model
  import bor_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Enable from the block, commands from the bench.
  input  wire logic       enable,
  input  wire logic [3:0] settle,
  input  wire logic       supply_low,
  // Detector outputs.
  output bor_det_s        det
);
  logic [3:0] warm_cnt;
  // Ready only after enable has stood settle cycles, at once when settle is zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      warm_cnt <= 4'h0;
    else if (!enable)
      warm_cnt <= 4'h0;
    else if (warm_cnt != settle)
      warm_cnt <= warm_cnt + 4'h1;
  end
  // A disabled detector is never ready; low follows the bench.
  assign det.ready = enable && (warm_cnt == settle);
  assign det.low   = supply_low;
endmodule

// ==== bench/bor_mode_ctrl_asserts.sv ====
// Assertions on the brown-out mode control ports.
`timescale 1ns/10ps
module bor_mode_ctrl_asserts
  import bor_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [1:0]          brownout_mode_cfg,
  input wire logic                sw_brownout_enable,
  input wire bor_det_s            det,
  input wire logic                power_on_reset,
  input wire logic                wake_req,
  // Outputs.
  input wire logic                brownout_ready_flag,
  input wire logic                brownout_active,
  input wire logic                detector_enable,
  input wire logic                core_reset,
  input wire logic                sleeping,
  input wire logic [BOR_NSRC-1:0] reset_flags
);
  // ==================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Short names for the mode and a healthy supply.
  wire [1:0] md = brownout_mode_cfg;
  wire       ok = det.ready && !det.low;
  a_on_enable:
    assert property (md == BOR_MODE_ON |-> detector_enable)
    else $error("mode 11 detector off");
  a_noslp_enable:
    assert property (md == BOR_MODE_NOSLP |->
      (sleeping ? (wake_req || !detector_enable) : detector_enable))
    else $error("mode 10 enable wrong");
  a_sw_enable:
    assert property (md == BOR_MODE_SW |->
      detector_enable == sw_brownout_enable)
    else $error("mode 01 enable wrong");
  a_off_enable:
    assert property (md == BOR_MODE_OFF |-> !detector_enable)
    else $error("mode 00 detector on");
  a_ready_copy:
    assert property ($past(rst_n) |-> brownout_ready_flag ==
      $past(det.ready) && brownout_active == (detector_enable &&
      det.ready && !(sleeping && md == BOR_MODE_NOSLP)))
    else $error("ready flag or active wrong");
  a_trip_reset:
    assert property (brownout_active && det.low |=>
      core_reset && reset_flags[BOR_SRC_BOR])
    else $error("trip without reset");
  a_por_record:
    assert property (power_on_reset |=>
      core_reset && reset_flags[BOR_SRC_POR])
    else $error("power-on not recorded");
  a_wake_fast:
    assert property (sleeping && wake_req && md == BOR_MODE_ON |=> !sleeping)
    else $error("mode 11 wake delayed");
  a_wake_wait:
    assert property (sleeping && wake_req && md == BOR_MODE_NOSLP && !ok
      |=> sleeping || core_reset)
    else $error("mode 10 woke early");
  // Main scenarios.
  cover property (sleeping && wake_req && md == BOR_MODE_NOSLP && !ok);
  cover property (brownout_active && det.low);
  cover property ($fell(core_reset));
endmodule
bind bor_mode_ctrl bor_mode_ctrl_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .brownout_mode_cfg(brownout_mode_cfg),
  .sw_brownout_enable(sw_brownout_enable), .det(det),
  .power_on_reset(power_on_reset), .wake_req(wake_req),
  .brownout_ready_flag(brownout_ready_flag),
  .brownout_active(brownout_active), .detector_enable(detector_enable),
  .core_reset(core_reset), .sleeping(sleeping),
  .reset_flags(reset_flags));

// ==== bench/tb_bor_mode_ctrl.sv ====
// Self-checking bench for the brown-out mode control block.
`timescale 1ns/10ps
module tb_bor_mode_ctrl
  import bor_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] mode = BOR_MODE_ON;
  logic       sw_en = 1'b0;
  logic       slp = 1'b0;
  logic       wk = 1'b0;
  logic       low = 1'b0;
  logic [8:0] evt = 9'h000;
  logic [8:0] clr = 9'h000;
  logic [8:0] flags;
  logic       rdy_f, act, den, crst, slpg;
  bor_det_s   det;
  int         fails = 0, checked = 0, cyc = 0, n;
  // Timer shortened to 8 cycles to keep the run brief.
  bor_mode_ctrl #(.PWRT_CYCLES(14'h0008)) dut (
    .clk(clk), .rst_n(rst_n), .brownout_mode_cfg(mode),
    .pwrt_enable(1'b1), .sw_brownout_enable(sw_en), .det(det),
    .power_on_reset(evt[0]), .low_power_brownout_reset(evt[2]),
    .master_clear_pin(evt[3]), .watchdog_timeout(evt[4]),
    .reset_instr(evt[5]), .stack_overflow(evt[6]),
    .stack_underflow(evt[7]), .prog_mode_exit(evt[8]),
    .sleep_req(slp), .wake_req(wk), .src_clr(clr),
    .brownout_ready_flag(rdy_f), .brownout_active(act),
    .detector_enable(den), .core_reset(crst), .sleeping(slpg),
    .reset_flags(flags));
  bor_det_model det_mdl (.clk(clk), .rst_n(rst_n), .enable(den),
    .settle(4'h6), .supply_low(low), .det(det));
  // ==================================================================
  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  // ==================================================================
  // Tasks
  task automatic stop_test;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Counts cycles until core_reset (w=0) or sleeping (w=1) drops.
  task automatic wait_low(input bit w, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while ((w ? slpg : crst) !== 1'b0 && c < 60);
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    tick(1);
    evt[i] <= 1'b0;
  endtask
  // Sleep in mode m, check enable, then wake within lo..hi cycles.
  task automatic nap(input logic [1:0] m, input logic en, int lo, int hi);
    mode <= m;
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(1);
    #1;
    chk({slpg, den, act}, {1'b1, en, en});
    tick(1);
    wk <= 1'b1;
    wait_low(1'b1, n);
    wk <= 1'b0;
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask
  // ==================================================================
  // Main sequence
  initial begin
    tick(12);
    rst_n <= 1'b1;
    wait_low(1'b0, n);
    chk(16'(n >= 6 && n < 60), 16'h0001);
    chk(rdy_f, 1'b1);
    pulse(0);
    wait_low(1'b0, n);
    chk(flags, 9'h001);
    chk(16'(n >= 8 && n < 60), 16'h0001);
    for (int i = 2; i < 9; i++) begin
      clr <= 9'h1FF;
      tick(1);
      clr <= 9'h000;
      pulse(i);
      wait_low(1'b0, n);
      chk(flags, 16'(9'h001 << i));
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      mode <= m[2:1];
      sw_en <= m[0];
      #1;
      chk(den, m[2] | (m[2:1] == 2'h1 & m[0]));
    end
    tick(1);
    nap(BOR_MODE_ON, 1'b1, 1, 1);
    nap(BOR_MODE_NOSLP, 1'b0, 6, 40);
    nap(BOR_MODE_SW, 1'b1, 1, 3);
    mode <= BOR_MODE_ON;
    low <= 1'b1;
    tick(2);
    #1;
    chk({crst, flags[1]}, 2'b11);
    tick(1);
    low <= 1'b0;
    mode <= BOR_MODE_SW;
    sw_en <= 1'b0;
    wait_low(1'b0, n);
    pulse(3);
    wait_low(1'b0, n);
    chk(16'(n <= 4), 16'h0001);
    pulse(0);
    tick(20);
    #1;
    chk(crst, 1'b1);
    tick(1);
    sw_en <= 1'b1;
    wait_low(1'b0, n);
    chk(16'(n < 60), 16'h0001);
    stop_test();
  end
endmodule
